// [rtl/angle_spi_defs.vh]
`ifndef ANGLE_SPI_DEFS_VH
`define ANGLE_SPI_DEFS_VH
`define ANGLE_W 13
`define DATA_W 14
`define FRAME_W 16
`define SENSOR_W 15
`define BIT_CNT_W 5
`define ERR_CODE_RESET 2'h0
`define ERR_CODE_MAGNET 2'h1
`define LOST_THRESH_RESET 15'h0_00F
`endif

// [rtl/odd_parity7.v]
`timescale 1ns/1ns
`default_nettype none
// odd parity over a seven bit slice
module odd_parity7
(
  // data in
  input wire [6:0] i_bits,
  // parity out
  output wire o_parity
);
  // inverted xor makes the total count of ones odd
  assign o_parity = ~(^i_bits);
endmodule
`default_nettype wire

// [rtl/angle_sensor_spi_output.v]
`timescale 1ns/1ns
`default_nettype none
`include "angle_spi_defs.vh"
module angle_sensor_spi_output
(
  // clock and reset
  input wire i_ref_clk,
  input wire i_rst_n,
  // measurement from the angle calculation
  input wire [`ANGLE_W-1:0] i_angle,
  input wire i_angle_valid,
  // offset corrected sensor magnitudes and threshold
  input wire [`SENSOR_W-1:0] i_sensor1_mag,
  input wire [`SENSOR_W-1:0] i_sensor2_mag,
  input wire [`SENSOR_W-1:0] i_lost_thresh,
  // spi pins
  input wire i_spi_clk,
  input wire i_spi_cs_n,
  output wire o_spi_data,
  // status
  output wire o_error_flag_bit,
  output wire o_busy
);
  // pin synchronisers, two flops before any use
  reg clk_s1_q;
  reg clk_s2_q;
  reg clk_s3_q;
  reg cs_s1_q;
  reg cs_s2_q;
  reg cs_s3_q;
  always @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      clk_s1_q <= 1'b1;
      clk_s2_q <= 1'b1;
      clk_s3_q <= 1'b1;
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      cs_s3_q <= 1'b1;
    end
    else
    begin
      clk_s1_q <= i_spi_clk;
      clk_s2_q <= clk_s1_q;
      clk_s3_q <= clk_s2_q;
      cs_s1_q <= i_spi_cs_n;
      cs_s2_q <= cs_s1_q;
      cs_s3_q <= cs_s2_q;
    end
  end

  // edge detection on synchronised levels
  wire cs_fall = cs_s3_q & ~cs_s2_q;
  wire cs_active = ~cs_s2_q;
  wire sclk_fall = clk_s3_q & ~clk_s2_q;

  // hold latest measurement; no valid value until first sample after reset
  reg [`ANGLE_W-1:0] angle_q;
  reg have_value_q;
  always @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      angle_q <= {`ANGLE_W{1'b0}};
      have_value_q <= 1'b0;
    end
    else if (i_angle_valid)
    begin
      angle_q <= i_angle;
      have_value_q <= 1'b1;
    end
  end

  // magnet lost only when both channels are weak together
  wire magnet_lost = (i_sensor1_mag < i_lost_thresh) &&
                     (i_sensor2_mag < i_lost_thresh);
  wire err = ~have_value_q | magnet_lost;

  // assemble the 14 bit word
  reg [`DATA_W-1:0] word;
  always @*
  begin
    if (!err)
      word = {1'b0, angle_q};
    else if (!have_value_q)
      word = {1'b1, angle_q[12:2], `ERR_CODE_RESET};
    else
      word = {1'b1, angle_q[12:2], `ERR_CODE_MAGNET};
  end

  // parity per byte
  wire upper_byte_parity;
  wire lower_byte_parity;
  odd_parity7 u_par_hi
  (
    .i_bits(word[13:7]),
    .o_parity(upper_byte_parity)
  );
  odd_parity7 u_par_lo
  (
    .i_bits(word[6:0]),
    .o_parity(lower_byte_parity)
  );

  // upper byte first, msb first; parity closes each byte
  wire [`FRAME_W-1:0] frame = {word[13:7], upper_byte_parity,
                               word[6:0], lower_byte_parity};

  // shift register; a frame holds one snapshot so both bytes agree
  reg [`FRAME_W-1:0] shift_q;
  reg [`BIT_CNT_W-1:0] cnt_q;
  reg first_q;
  reg data_q;
  always @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      shift_q <= {`FRAME_W{1'b0}};
      cnt_q <= {`BIT_CNT_W{1'b0}};
      first_q <= 1'b0;
      data_q <= 1'b0;
    end
    else if (!cs_active)
    begin
      data_q <= 1'b0;
      first_q <= 1'b0;
      cnt_q <= {`BIT_CNT_W{1'b0}};
    end
    else if (cs_fall)
    begin
      shift_q <= frame;
      cnt_q <= {`BIT_CNT_W{1'b0}};
      first_q <= 1'b1;
      data_q <= 1'b0;
    end
    else if (sclk_fall)
    begin
      // first falling edge presents the msb, later ones shift; no edges, no move
      if (cnt_q < `FRAME_W)
      begin
        data_q <= shift_q[`FRAME_W-1];
        shift_q <= {shift_q[`FRAME_W-2:0], 1'b0};
        cnt_q <= cnt_q + 5'h1;
      end
      else
        data_q <= 1'b0;
      first_q <= 1'b0;
    end
  end

  // outputs
  assign o_spi_data = data_q;
  assign o_error_flag_bit = err;
  assign o_busy = cs_active & (cnt_q != 5'h0 | first_q);
endmodule
`default_nettype wire

// [dv/angle_spi_master.sv]
`timescale 1ns/1ns
`default_nettype none
// far side master; pins named as seen from the sensor
module angle_spi_master(input wire i_ref_clk, o_spi_data, output logic i_spi_clk = 1,
  i_spi_cs_n = 1);
  // clock idles high, falls to shift, rises to sample
  task automatic xfer(input int hold, nb, output logic [15:0] w);
    #200 i_spi_cs_n = 0;
    for (int n = 15; n > 15 - nb; n--) begin
      #(n == 15 ? 1400 : 160) i_spi_clk = 0; // long lead before first fall
      #160 i_spi_clk = 1;
      w[n] = o_spi_data;
      if (n == 8) #(hold); // pause with clock high
    end
    #160 i_spi_cs_n = 1; // all nb bits in one select
  endtask
endmodule
`default_nettype wire

// [dv/angle_spi_chk_asserts.sv]
`timescale 1ns/1ns
`default_nettype none
module angle_spi_chk(input wire i_ref_clk, i_rst_n, i_angle_valid, i_spi_clk, i_spi_cs_n,
  o_spi_data, o_error_flag_bit, o_busy, input wire [14:0] i_sensor1_mag, i_sensor2_mag,
  i_lost_thresh);
  wire lost = i_sensor1_mag < i_lost_thresh && i_sensor2_mag < i_lost_thresh;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  // figures allow for the pin synchronisers
  property p_idle; i_spi_cs_n [*6] |-> !o_spi_data; endproperty
  a_idle: assert property (p_idle) else $error("idle");
  property p_end; $rose(i_spi_cs_n) |-> ##[2:6] !o_spi_data; endproperty
  a_end: assert property (p_end) else $error("end");
  property p_free; i_spi_cs_n [*6] |-> !o_busy; endproperty
  a_free: assert property (p_free) else $error("busy");
  property p_go; $fell(i_spi_cs_n) |-> ##[1:40] o_busy; endproperty
  a_go: assert property (p_go) else $error("go");
  property p_hold; (i_spi_clk && !i_spi_cs_n) [*6] |-> $stable(o_spi_data); endproperty
  a_hold: assert property (p_hold) else $error("moved");
  property p_lost; lost |-> o_error_flag_bit; endproperty
  a_lost: assert property (p_lost) else $error("lost");
  property p_ok; i_angle_valid ##2 !lost |-> !o_error_flag_bit; endproperty
  a_ok: assert property (p_ok) else $error("flag");
  property p_rst; $rose(i_rst_n) |-> o_error_flag_bit; endproperty
  a_rst: assert property (p_rst) else $error("code");
  cover property (lost && o_busy);
  cover property (o_busy);
  cover property ($rose(o_spi_data));
endmodule
bind angle_sensor_spi_output angle_spi_chk angle_spi_chk_inst(.*);
`default_nettype wire

// [dv/test_angle_sensor_spi_output.sv]
`timescale 1ns/1ns
`default_nettype none
module test_angle_sensor_spi_output;
  logic i_ref_clk = 0, i_rst_n = 0, i_angle_valid = 0, i_spi_clk, i_spi_cs_n, o_spi_data;
  logic o_error_flag_bit, o_busy;
  logic [12:0] i_angle = 0;
  logic [13:0] x;
  logic [14:0] i_sensor1_mag = 15'h0100, i_sensor2_mag = 15'h0100, i_lost_thresh = 15'h000f;
  logic [15:0] w;
  int err_total = 0, n_tests = 0, i;
  angle_sensor_spi_output angle_sensor_spi_output_inst(.*);
  angle_spi_master angle_spi_master_inst(.*);
  initial forever #20 i_ref_clk = ~i_ref_clk;
  // two bytes, odd parity after each seven bits
  function automatic [15:0] fr(input [13:0] d);
    return {d[13:7], ~^d[13:7], d[6:0], ~^d[6:0]};
  endfunction
  task chk(input [15:0] s, e);
    n_tests++;
    if (s !== e) begin err_total++; $display("BAD %0t %h %h", $time, s, e); end
  endtask
  task complete_run;
    $display("%0d bad of %0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // frame 2 aborts early, frame 5 loses the magnet
  initial begin
    i = $urandom(32'h4722_7f49);
    #80 i_rst_n = 1;
    angle_spi_master_inst.xfer(0, 16, w);
    chk(w, fr(14'h2000));
    for (i = 0; i < 6; i++) begin
      @(negedge i_ref_clk) i_angle = i ? 13'($urandom) : 13'h1fff;
      i_angle_valid = 1;
      @(negedge i_ref_clk) i_angle_valid = 0;
      if (i == 5) i_sensor1_mag = 15'($urandom % 15);
      if (i == 5) i_sensor2_mag = 0;
      x = i == 5 ? {1'b1, i_angle[12:2], 2'h1} : {1'b0, i_angle};
      angle_spi_master_inst.xfer(i * 400, i == 2 ? 5 : 16, w);
      if (i != 2) chk(w, fr(x));
    end
    complete_run;
  end
endmodule
`default_nettype wire
